// ==== logic/bls_strobe_top.sv ====
// byte lane strobe mapper: bank decode, switch gap, pin mapping, registers
`timescale 1ns/100ps
module bls_strobe_top
  import bls_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // core access request
  input wire logic ACC_VALID_I,
  input wire logic [ADDR_W-1:0] ACC_ADDR_I,
  input wire logic ACC_READ_I,
  input wire logic ACC_IO_I,
  output logic ACC_READY_O,
  // strap pin
  input wire logic PROGRAM_WIDTH_PIN_I,
  // external memory pins
  output logic [ADDR_W-1:0] EXT_ADDR_O,
  output logic PRIMARY_BANK_STROBE_N_O,
  output logic SECONDARY_BANK_STROBE_N_O,
  output logic IO_SPACE_STROBE_N_O,
  output logic [3:0] PRIM_BYTE_ENABLE_N_O,
  output logic [3:0] SEC_BYTE_ENABLE_N_O
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] prim_ctrl_reg;
  logic [31:0] sec_ctrl_reg;
  logic [31:0] io_ctrl_reg;
  logic [31:0] hrdata_reg;
  logic hready_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] ofs_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  bls_state_t state_reg;
  bls_state_t state_next;
  logic last_read_reg;
  logic last_sec_reg;
  logic last_prim_reg;
  logic [ADDR_W-1:0] hold_addr_reg;
  logic hold_read_reg;
  logic hold_io_reg;
  logic [7:0] gap_count_reg;
  logic take;
  logic need_gap;
  logic req_sec;
  logic req_prim;
  logic [ADDR_W-1:0] cur_addr;
  logic cur_read;
  logic cur_io;
  logic cur_sec;
  logic cur_prim;
  logic cur_go;
  logic [31:0] sel_ctrl;
  logic [3:0] pin_next [2];
  logic [1:0] bank_width [2];
  logic bank_lane_on [2];
  logic addr_ph;
  bls_map_if mif ();

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  // address phase of a selected, ready transfer
  assign addr_ph = HSEL_I & HREADY_I & HTRANS_I[1];

  // phase tracking; reads add one wait so they see completed writes
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      ofs_reg <= 8'h00;
      hready_reg <= 1'b1;
    end else begin
      wr_pend_reg <= addr_ph & HWRITE_I;
      rd_pend_reg <= addr_ph & ~HWRITE_I;
      if (addr_ph) begin
        ofs_reg <= HADDR_I[7:0];
      end
      hready_reg <= ~(addr_ph & ~HWRITE_I);
    end
  end

  // read data, unmapped offsets read zero
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      case (ofs_reg)
        OFS_IO_CTRL: hrdata_reg <= io_ctrl_reg;
        OFS_PRIM_CTRL: hrdata_reg <= prim_ctrl_reg;
        OFS_SEC_CTRL: hrdata_reg <= sec_ctrl_reg;
        OFS_STATUS: hrdata_reg <= {16'h0000, gap_count_reg, 2'b00,
          last_prim_reg, last_sec_reg, last_read_reg, state_reg};
        default: hrdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign HRDATA_O = hrdata_reg;
  assign HREADYOUT_O = hready_reg;
  assign HRESP_O = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture for the width fields

  // two-flop synchroniser on the program-width pin
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= PROGRAM_WIDTH_PIN_I;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // wait until the synchroniser holds a real sample
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      strap_done_reg <= (strap_cnt_reg == STRAP_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // primary bank control, holds the shared-lane and gap bits
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      prim_ctrl_reg <= BANK_RST;
    end else if (!strap_done_reg && strap_cnt_reg == STRAP_WAIT && pin_sync_reg) begin
      prim_ctrl_reg[WID_LSB+:2] <= WID_STRAP_HI;
    end else if (wr_pend_reg && ofs_reg == OFS_PRIM_CTRL) begin
      prim_ctrl_reg <= (HWDATA_I & PRIM_WMASK) | (prim_ctrl_reg & ~PRIM_WMASK);
    end
  end

  // secondary bank control
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sec_ctrl_reg <= BANK_RST;
    end else if (!strap_done_reg && strap_cnt_reg == STRAP_WAIT && pin_sync_reg) begin
      sec_ctrl_reg[WID_LSB+:2] <= WID_STRAP_HI;
    end else if (wr_pend_reg && ofs_reg == OFS_SEC_CTRL) begin
      sec_ctrl_reg <= (HWDATA_I & SEC_WMASK) | (sec_ctrl_reg & ~SEC_WMASK);
    end
  end

  // i/o space control, stored only
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      io_ctrl_reg <= IO_RST;
    end else if (wr_pend_reg && ofs_reg == OFS_IO_CTRL) begin
      io_ctrl_reg <= (HWDATA_I & IO_WMASK) | (io_ctrl_reg & ~IO_WMASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer

  // bank decode of the incoming request
  assign req_sec = ~ACC_IO_I & (ACC_ADDR_I >= SEC_BEG);
  assign req_prim = ~ACC_IO_I & ((ACC_ADDR_I < PRIM_LO_END) |
    ((ACC_ADDR_I >= PRIM_HI_BEG) & (ACC_ADDR_I < SEC_BEG)));
  assign take = ACC_VALID_I & ACC_READY_O;

  // a read switching banks right after a read needs the idle cycle
  assign need_gap = take & ACC_READ_I & last_read_reg & prim_ctrl_reg[BIT_GAP] &
    ((req_sec & last_prim_reg) | (req_prim & last_sec_reg));

  // next state
  always_comb begin
    state_next = ST_IDLE;
    case (state_reg)
      ST_IDLE, ST_ACC: begin
        if (need_gap) begin
          state_next = ST_GAP;
        end else if (take) begin
          state_next = ST_ACC;
        end
      end
      ST_GAP: state_next = ST_ACC;
      default: state_next = ST_IDLE;
    endcase
  end

  // state and the request held across the gap
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg <= ST_IDLE;
      hold_addr_reg <= 24'h00_0000;
      hold_read_reg <= 1'b0;
      hold_io_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (take) begin
        hold_addr_reg <= ACC_ADDR_I;
        hold_read_reg <= ACC_READ_I;
        hold_io_reg <= ACC_IO_I;
      end
    end
  end

  // the access that drives the pins this edge
  assign cur_go = (take & ~need_gap) | (state_reg == ST_GAP);
  assign cur_addr = (state_reg == ST_GAP) ? hold_addr_reg : ACC_ADDR_I;
  assign cur_read = (state_reg == ST_GAP) ? hold_read_reg : ACC_READ_I;
  assign cur_io = (state_reg == ST_GAP) ? hold_io_reg : ACC_IO_I;
  assign cur_sec = ~cur_io & (cur_addr >= SEC_BEG);
  assign cur_prim = ~cur_io & ~cur_sec & ((cur_addr < PRIM_LO_END) |
    (cur_addr >= PRIM_HI_BEG));

  // history of the last driven access, and a gap counter for software
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      last_read_reg <= 1'b0;
      last_sec_reg <= 1'b0;
      last_prim_reg <= 1'b0;
      gap_count_reg <= 8'h00;
    end else begin
      last_read_reg <= cur_go & cur_read;
      last_sec_reg <= cur_go & cur_sec;
      last_prim_reg <= cur_go & cur_prim;
      if (need_gap) begin
        gap_count_reg <= gap_count_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin mapping

  // mapping follows the config of the bank being accessed
  assign sel_ctrl = cur_sec ? sec_ctrl_reg : prim_ctrl_reg;
  assign mif.addr = cur_addr;
  assign mif.width = cur_io ? SZ_32 : size_dec(sel_ctrl[WID_LSB+:2]);
  assign mif.dsize = cur_io ? SZ_32 : size_dec(sel_ctrl[SIZE_LSB+:2]);

  bls_addr_map u_map (
    .m (mif.mapper)
  );

  assign bank_width[0] = prim_ctrl_reg[WID_LSB+:2];
  assign bank_width[1] = sec_ctrl_reg[WID_LSB+:2];
  assign bank_lane_on[0] = cur_prim | (cur_sec & prim_ctrl_reg[BIT_SHARED]);
  assign bank_lane_on[1] = cur_sec;

  // per bank: narrow-width pins carry mif.lo_bits on every cycle, whichever bank or space is accessed
  for (genvar b = 0; b < 2; b++) begin : g_bank
    always_comb begin
      pin_next[b] = ~(mif.be & {4{cur_go & bank_lane_on[b]}});
      if (size_dec(bank_width[b]) != SZ_32) begin
        pin_next[b][3] = mif.lo_bits[1];
      end
      if (size_dec(bank_width[b]) == SZ_8) begin
        pin_next[b][2] = mif.lo_bits[0];
      end
    end
  end

  // registered pins; a gap cycle leaves all strobes high
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      EXT_ADDR_O <= 24'h00_0000;
      PRIMARY_BANK_STROBE_N_O <= 1'b1;
      SECONDARY_BANK_STROBE_N_O <= 1'b1;
      IO_SPACE_STROBE_N_O <= 1'b1;
      PRIM_BYTE_ENABLE_N_O <= 4'hF;
      SEC_BYTE_ENABLE_N_O <= 4'hF;
      ACC_READY_O <= 1'b1;
    end else begin
      ACC_READY_O <= ~need_gap;
      PRIMARY_BANK_STROBE_N_O <= ~(cur_go & cur_prim);
      SECONDARY_BANK_STROBE_N_O <= ~(cur_go & cur_sec);
      IO_SPACE_STROBE_N_O <= ~(cur_go & cur_io);
      PRIM_BYTE_ENABLE_N_O <= pin_next[0];
      SEC_BYTE_ENABLE_N_O <= pin_next[1];
      if (cur_go) begin
        EXT_ADDR_O <= mif.ext_addr;
      end
    end
  end

endmodule // bls_strobe_top

// ==== shared/bls_pkg.sv ====
// constants, types and decode helpers shared by the strobe mapper files
package bls_pkg;

  // internal and external address width
  localparam int ADDR_W = 24;

  // register byte offsets within the block
  localparam logic [7:0] OFS_IO_CTRL = 8'h60;
  localparam logic [7:0] OFS_PRIM_CTRL = 8'h64;
  localparam logic [7:0] OFS_SEC_CTRL = 8'h68;
  localparam logic [7:0] OFS_STATUS = 8'h70;

  // field positions in the bank control registers
  localparam int BIT_GAP = 22;
  localparam int BIT_SHARED = 21;
  localparam int WID_LSB = 18;
  localparam int SIZE_LSB = 16;

  // reset values and writable bit masks
  localparam logic [31:0] BANK_RST = 32'h000F_10F8;
  localparam logic [31:0] IO_RST = 32'h0000_00F8;
  localparam logic [31:0] PRIM_WMASK = 32'h007F_1FF8;
  localparam logic [31:0] SEC_WMASK = 32'h001F_1FF8;
  localparam logic [31:0] IO_WMASK = 32'h0000_00F8;
  localparam logic [1:0] WID_STRAP_HI = 2'b01;

  // bank address boundaries
  localparam logic [23:0] PRIM_LO_END = 24'h80_0000;
  localparam logic [23:0] PRIM_HI_BEG = 24'h88_0000;
  localparam logic [23:0] SEC_BEG = 24'h90_0000;

  // cycles after reset release before the strap pin is trusted
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // decoded width or data size
  typedef enum logic [1:0] {
    SZ_8 = 2'b00,
    SZ_16 = 2'b01,
    SZ_32 = 2'b11
  } bls_size_t;

  // access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACC = 3'b010,
    ST_GAP = 3'b100
  } bls_state_t;

  // size field decode, the reserved code is served as 32 bits
  function automatic bls_size_t size_dec(input logic [1:0] f);
    case (f)
      2'b00: size_dec = SZ_8;
      2'b01: size_dec = SZ_16;
      default: size_dec = SZ_32;
    endcase
  endfunction

endpackage

// ==== shared/bls_map_if.sv ====
// carrier between the sequencer and the address and byte enable mapper
`timescale 1ns/100ps
interface bls_map_if;
  import bls_pkg::*;
  logic [ADDR_W-1:0] addr;
  bls_size_t width;
  bls_size_t dsize;
  logic [ADDR_W-1:0] ext_addr;
  logic [3:0] be;
  logic [1:0] lo_bits;
  modport mapper (input addr, input width, input dsize,
    output ext_addr, output be, output lo_bits);
  modport user (output addr, output width, output dsize,
    input ext_addr, input be, input lo_bits);
endinterface

// ==== logic/bls_addr_map.sv ====
// address shift and byte enable mapping for one access
`timescale 1ns/100ps
module bls_addr_map
  import bls_pkg::*;
(
  bls_map_if.mapper m
);

  logic [ADDR_W-1:0] a;
  logic [ADDR_W-1:0] sh1;
  logic [ADDR_W-1:0] sh2;

  // shifted forms, top bit copied into the freed positions
  assign a = m.addr;
  assign sh1 = {{2{a[23]}}, a[22:1]};
  assign sh2 = {{3{a[23]}}, a[22:2]};

  // shift, enables and the low address bits carried on strobe pins
  always_comb begin
    m.ext_addr = a;
    m.be = 4'h0;
    m.lo_bits = 2'b00;
    case (m.width)
      SZ_32: begin
        case (m.dsize)
          SZ_8: begin
            m.ext_addr = sh2;
            m.be = 4'h1 << a[1:0];
          end
          SZ_16: begin
            m.ext_addr = sh1;
            m.be = a[0] ? 4'hC : 4'h3;
          end
          default: m.be = 4'hF;
        endcase
      end
      SZ_16: begin
        case (m.dsize)
          SZ_8: begin
            m.ext_addr = sh2;
            m.lo_bits = {a[1], 1'b0};
            m.be = a[0] ? 4'h2 : 4'h1;
          end
          SZ_16: begin
            m.ext_addr = sh1;
            m.lo_bits = {a[0], 1'b0};
            m.be = 4'h3;
          end
          default: m.be = 4'h3;
        endcase
      end
      default: begin
        m.be = 4'h1;
        case (m.dsize)
          SZ_8: begin
            m.ext_addr = sh2;
            m.lo_bits = a[1:0];
          end
          SZ_16: begin
            m.ext_addr = sh1;
            m.lo_bits = {a[0], 1'b0};
          end
          default: m.lo_bits = 2'b00;
        endcase
      end
    endcase
  end

endmodule // bls_addr_map

// ==== dv/bls_strobe_top_assertions.sv ====
// port-level checks for the byte lane strobe mapper
`timescale 1ns/100ps
module bls_strobe_top_assertions (
  // clock, reset and bus
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic HSEL_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  // access port and strobes
  input wire logic ACC_VALID_I,
  input wire logic [23:0] ACC_ADDR_I,
  input wire logic ACC_IO_I,
  input wire logic ACC_READY_O,
  input wire logic PRIMARY_BANK_STROBE_N_O,
  input wire logic SECONDARY_BANK_STROBE_N_O,
  input wire logic IO_SPACE_STROBE_N_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  ////////////////////////////////////////
  // decoded request terms
  wire logic hit = HSEL_I & HREADY_I & HTRANS_I[1];
  wire logic take = ACC_VALID_I & ACC_READY_O & ~ACC_IO_I;
  wire logic [2:0] stb = {PRIMARY_BANK_STROBE_N_O, SECONDARY_BANK_STROBE_N_O,
    IO_SPACE_STROBE_N_O};
  wire logic prim = (ACC_ADDR_I < 24'h80_0000) ||
    (ACC_ADDR_I >= 24'h88_0000 && ACC_ADDR_I < 24'h90_0000);
  sequence s_rd_req;
    hit && !HWRITE_I;
  endsequence
  sequence s_rd_done;
    !HREADYOUT_O ##1 HREADYOUT_O;
  endsequence
  ////////////////////////////////////////
  // bus answer timing
  a_read_wait: assert property (s_rd_req |=> s_rd_done)
    else $error("read wait state wrong");
  a_write_fast: assert property (hit && HWRITE_I |=> HREADYOUT_O)
    else $error("write stalled");
  a_resp_okay: assert property (HRESP_O == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property ($changed(HRDATA_O) |-> $past(!HREADYOUT_O))
    else $error("read data moved outside a read");
  // strobe behaviour
  a_one_strobe: assert property ($onehot0(~stb))
    else $error("two strobes low");
  a_gap_quiet: assert property (!ACC_READY_O |-> stb == 3'b111)
    else $error("strobe low in gap cycle");
  a_gap_once: assert property ($fell(ACC_READY_O) |=> ACC_READY_O)
    else $error("gap longer than one cycle");
  a_prim_take: assert property (take && prim |-> ##[1:2] !stb[2])
    else $error("primary strobe missing");
  a_sec_take: assert property (take && ACC_ADDR_I >= 24'h90_0000 |-> ##[1:2] !stb[1])
    else $error("secondary strobe missing");
endmodule // bls_strobe_top_assertions
bind bls_strobe_top bls_strobe_top_assertions u_chk (.CLK_I(CLK_I), .RESET_I(RESET_I),
  .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
  .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .ACC_VALID_I(ACC_VALID_I), .ACC_ADDR_I(ACC_ADDR_I), .ACC_IO_I(ACC_IO_I),
  .ACC_READY_O(ACC_READY_O), .PRIMARY_BANK_STROBE_N_O(PRIMARY_BANK_STROBE_N_O),
  .SECONDARY_BANK_STROBE_N_O(SECONDARY_BANK_STROBE_N_O),
  .IO_SPACE_STROBE_N_O(IO_SPACE_STROBE_N_O));

// ==== dv/bls_mem_model.sv ====
// external bank model: records the pins of each selected memory cycle
`timescale 1ns/100ps
module bls_mem_model (
  // clock
  input wire logic clk_i,
  // memory pins
  input wire logic [23:0] addr_i,
  input wire logic prim_stb_n_i,
  input wire logic sec_stb_n_i,
  input wire logic [3:0] prim_be_n_i,
  input wire logic [3:0] sec_be_n_i,
  // lanes and address of the last selected cycle
  output logic [31:0] last_o
);
  // memory latches the cycle at its end, as an async sram would
  always_ff @(posedge clk_i) begin
    if (!prim_stb_n_i || !sec_stb_n_i) begin
      last_o <= {prim_be_n_i, sec_be_n_i, addr_i};
    end
  end
endmodule // bls_mem_model

// ==== dv/testbench.sv ====
// self-checking bench for the byte lane strobe mapper
`timescale 1ns/100ps
module testbench;
  import bls_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic valid = 1'b0;
  logic [23:0] aaddr = 24'h00_0000;
  logic aio = 1'b0;
  logic aread = 1'b1;
  logic strap = 1'b0;
  logic [31:0] rd;
  wire logic [31:0] hrdata;
  wire logic [31:0] last;
  wire logic [23:0] eaddr;
  wire logic [3:0] pbe, sbe;
  wire logic hready, hresp, ardy, pstb, sstb, istb;
  int error_cnt = 0;
  int tests_run = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  ////////////////////////////////////////
  bls_strobe_top u_dut (.CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .ACC_VALID_I(valid), .ACC_ADDR_I(aaddr), .ACC_READ_I(aread), .ACC_IO_I(aio),
    .ACC_READY_O(ardy), .PROGRAM_WIDTH_PIN_I(strap), .EXT_ADDR_O(eaddr),
    .PRIMARY_BANK_STROBE_N_O(pstb), .SECONDARY_BANK_STROBE_N_O(sstb),
    .IO_SPACE_STROBE_N_O(istb), .PRIM_BYTE_ENABLE_N_O(pbe), .SEC_BYTE_ENABLE_N_O(sbe));
  bls_mem_model u_mem (.clk_i(clk), .addr_i(eaddr), .prim_stb_n_i(pstb),
    .sec_stb_n_i(sstb), .prim_be_n_i(pbe), .sec_be_n_i(sbe), .last_o(last));
  ////////////////////////////////////////
  // bank control word from width, size, shared-lane and gap
  function automatic logic [31:0] cfg(input logic [1:0] w, input logic [1:0] s,
    input logic sh, input logic gp);
    return {9'h000, gp, sh, 1'b0, w, s, 16'h10F8};
  endfunction
  // expected primary lanes, secondary lanes and address on a 32-wide bank
  function automatic logic [31:0] exp_map(input logic [1:0] s, input logic [23:0] a);
    logic [23:0] x;
    logic [3:0] be;
    x = (s == 2'b00) ? {a[23], a[23], a[23:2]} : (s == 2'b01) ? {a[23], a[23:1]} : a;
    be = (s == 2'b00) ? ~(4'h1 << a[1:0]) : (s == 2'b01) ? (a[0] ? 4'h3 : 4'hC) : 4'h0;
    return {4'hF, be, x};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // wait for ready of the bus or of the access port, bounded
  task automatic wait_on(input logic port);
    int n;
    n = 0;
    @(posedge clk);
    while ((port ? ardy : hready) !== 1'b1) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask
  // one ahb-lite single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_on(1'b0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(1'b0);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    cmp(rd, exp);
  endtask
  // core access request, read or write as aread is set, held until taken
  task automatic acc(input logic [23:0] a, input logic io);
    valid <= 1'b1;
    aaddr <= a;
    aio <= io;
    wait_on(1'b1);
  endtask
  task automatic stop_acc;
    valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic s);
    rst <= 1'b1;
    strap <= s;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    do_reset(1'b0);
    rchk(OFS_PRIM_CTRL, BANK_RST);
    rchk(OFS_SEC_CTRL, BANK_RST);
    rchk(OFS_IO_CTRL, IO_RST);
    rchk(8'h6C, 32'h0000_0000);
    bus(1'b1, OFS_PRIM_CTRL, 32'hFFFF_FFFF);
    rchk(OFS_PRIM_CTRL, PRIM_WMASK);
    bus(1'b1, OFS_SEC_CTRL, 32'hFFFF_FFFF);
    rchk(OFS_SEC_CTRL, SEC_WMASK);
    bus(1'b1, OFS_PRIM_CTRL, cfg(2'b11, 2'b11, 1'b0, 1'b0));
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, OFS_SEC_CTRL, cfg(2'b11, 2'(s), 1'b0, 1'b0));
      for (int i = 0; i < 4; i++) begin
        acc(24'h90_4000 + 24'(i), 1'b0);
        stop_acc();
        cmp(last, exp_map(2'(s), 24'h90_4000 + 24'(i)));
      end
    end
    bus(1'b1, OFS_SEC_CTRL, cfg(2'b01, 2'b01, 1'b0, 1'b0));
    acc(24'h90_0001, 1'b0);
    stop_acc();
    cmp({4'h0, last[27:24] & 4'hB, last[23:0]}, 32'h08C8_0000);
    acc(24'h00_0100, 1'b1);
    #1;
    cmp({30'h0, istb, sbe[3]}, 32'h0000_0000);
    stop_acc();
    bus(1'b1, OFS_SEC_CTRL, cfg(2'b11, 2'b11, 1'b0, 1'b0));
    bus(1'b1, OFS_PRIM_CTRL, cfg(2'b11, 2'b11, 1'b1, 1'b0));
    acc(24'h90_4000, 1'b0);
    stop_acc();
    cmp(last, 32'h0090_4000);
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, OFS_PRIM_CTRL, cfg(2'b11, 2'b11, 1'b0, 1'(g)));
      for (int d = 0; d < 2; d++) begin
        acc(d ? 24'h90_0000 : 24'h00_4000, 1'b0);
        acc(d ? 24'h00_4000 : 24'h90_0000, 1'b0);
        #1;
        cmp({30'h0, pstb & sstb, ardy}, g ? 32'h2 : 32'h1);
        stop_acc();
        cmp({31'h0, d ? pstb : sstb}, g ? 32'h0 : 32'h1);
      end
    end
    // gap bit still set: a write on either side of a bank switch takes no gap
    for (int w = 0; w < 2; w++) begin
      aread <= 1'(w);
      acc(24'h00_4000, 1'b0);
      aread <= ~1'(w);
      acc(24'h90_0000, 1'b0);
      #1;
      cmp({30'h0, pstb & sstb, ardy}, 32'h1);
      stop_acc();
    end
    aread <= 1'b1;
    // same-bank back-to-back reads keep the strobe low with no gap
    acc(24'h00_4000, 1'b0);
    #1;
    cmp({31'h0, pstb}, 32'h0);
    acc(24'h00_4001, 1'b0);
    #1;
    cmp({30'h0, pstb, ardy}, 32'h1);
    stop_acc();
    // status: idle, no history, two gaps counted so far
    rchk(OFS_STATUS, 32'h0000_0201);
    do_reset(1'b1);
    rchk(OFS_SEC_CTRL, cfg(2'b01, 2'b11, 1'b0, 1'b0));
    wrap_up();
  end
endmodule // testbench
